// ---- rtl/prlc_regs.vh ----
// constants of the psram latency and refresh configuration block
// assumes a 20 ns core clock and a 32-bit apb register bus
`ifndef PRLC_REGS_VH
`define PRLC_REGS_VH
// apb byte offsets
`define PRLC_OFF_LATPWR 4'h0
`define PRLC_OFF_REFSLP 4'h4
`define PRLC_OFF_STATUS 4'h8
// latency_power_config fields
`define PRLC_CR0_DPD 15
`define PRLC_CR0_DRV_HI 14
`define PRLC_CR0_DRV_LO 12
`define PRLC_CR0_LAT_HI 7
`define PRLC_CR0_LAT_LO 4
`define PRLC_CR0_FIX 3
`define PRLC_CR0_BST_HI 2
// refresh_sleep_config fields
`define PRLC_CR1_CLK 6
`define PRLC_CR1_HS 5
`define PRLC_CR1_PAR_HI 4
`define PRLC_CR1_PAR_LO 2
// reset values
`define PRLC_RST_DRV 3'h0
`define PRLC_RST_LAT 4'h2
`define PRLC_RST_FIX 1'b1
`define PRLC_RST_BST 3'h7
`define PRLC_RST_CLK 1'b1
`define PRLC_RST_PAR 3'h0
`define PRLC_RST_RFI 2'h1
`define PRLC_CR0_RSVD 4'hf
`define PRLC_CR1_RSVD 9'h1ff
// timing
`define PRLC_CLK_NS 20
`define PRLC_WINDOW_NS 64000000
`define PRLC_ROWS 4096
`define PRLC_DPD_IN_NS 3000
`define PRLC_REF_CYC 4
`endif

// ---- rtl/prlc_sync.v ----
// two-flop synchroniser for pins arriving from outside the core clock
// assumes each bit is a slow level; no bus coherence between bits
module prlc_sync #(
   parameter W = 1,
   parameter [W-1:0] RSTV = {W{1'b0}}
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // async level in, synchronised level out
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] meta_q;

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         meta_q <= RSTV;
         q <= RSTV;
      end
      else
      begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule // prlc_sync

// ---- rtl/prlc_top.v ----
// latency signalling, configuration and self-refresh control of a psram
// assumes apb master on clk; link pins sampled by clk (link clock much slower)
// Notes on behaviour
// - initial latency 3..7 clocks from field
// - latency resets to 7 clocks
// - pending refresh: strobe high, double latency
// - register writes: zero latency, immediate capture
// - refresh may overlap register write capture
// - fixed latency: strobe high, always double
// - fixed latency set at reset
// - drive strength field, resets to 000
// - writing 0 enters deep sleep, refresh stops
// - deep sleep watches select; exits on pulse
// - clock type: 1 single-ended, 0 differential
// - partial refresh field limits refreshed rows
// - retention sleep set by write, select clears
// - interval field read-only, reads 01
// - refresh only while idle or in register write data
// - single rows spread evenly over window
// - deep sleep exit equals power-on state
//
// The APB slave port and the placing of the registers were left to the implementer.
`include "prlc_regs.vh"
module prlc_top #(
   parameter ROW_BITS = 12
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [3:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // link pins
   input wire cs_n_pin,
   input wire ck_pin,
   input wire [7:0] dq_pin,
   output reg strobe_mask_pin_o,
   output reg strobe_mask_pin_oe,
   // status towards the array and pads
   output reg data_phase,
   output reg [2:0] drive_strength,
   output reg clock_single_ended,
   output reg deep_sleep_state,
   output reg retention_sleep_state,
   output reg refresh_strobe,
   output reg [ROW_BITS-1:0] refresh_row
);
   localparam ROW_NS = `PRLC_WINDOW_NS / `PRLC_ROWS;
   localparam ROW_CYC = ROW_NS / `PRLC_CLK_NS;
   localparam DPD_CYC = `PRLC_DPD_IN_NS / `PRLC_CLK_NS;
   localparam [3:0] L_IDLE = 4'h1;
   localparam [3:0] L_CA = 4'h2;
   localparam [3:0] L_LAT = 4'h4;
   localparam [3:0] L_DATA = 4'h8;

   // latency clocks for a field value; reserved codes fall back to 7
   function [3:0] lat_clocks;
      input [3:0] f;
      begin
         case (f)
            4'h0: lat_clocks = 4'h5;
            4'h1: lat_clocks = 4'h6;
            4'he: lat_clocks = 4'h3;
            4'hf: lat_clocks = 4'h4;
            default: lat_clocks = 4'h7;
         endcase
      end
   endfunction

   // is the row inside the partial refresh range
   function in_range;
      input [2:0] par;
      input [ROW_BITS-1:0] row;
      begin
         case (par)
            3'h0: in_range = 1'b1;
            3'h1: in_range = ~row[ROW_BITS-1];
            3'h2: in_range = (row[ROW_BITS-1 -: 2] == 2'h0);
            3'h3: in_range = (row[ROW_BITS-1 -: 3] == 3'h0);
            3'h5: in_range = row[ROW_BITS-1];
            3'h6: in_range = (row[ROW_BITS-1 -: 2] == 2'h3);
            3'h7: in_range = (row[ROW_BITS-1 -: 3] == 3'h7);
            default: in_range = 1'b0;
         endcase
      end
   endfunction

   wire [9:0] pins_s;
   wire cs_n_s;
   wire ck_s;
   wire [7:0] dq_s;
   reg cs_n_d_q;
   reg ck_d_q;
   reg [3:0] st_q;
   reg [2:0] ecnt_q;
   reg [4:0] lcnt_q;
   reg [3:0] lat_txn_q;
   reg dbl_q;
   reg is_read_q;
   reg is_reg_q;
   reg reg_sel_q;
   reg byte_n_q;
   reg [7:0] hi_byte_q;
   reg [2:0] ctl_q;
   reg [3:0] lat_q;
   reg fix_q;
   reg dpd_bit_q;
   reg hs_q;
   reg [2:0] par_q;
   reg [15:0] dpd_cnt_q;
   reg [15:0] row_tmr_q;
   reg [ROW_BITS-1:0] row_q;
   reg [ROW_BITS-1:0] pend_row_q;
   reg ref_pend_q;
   reg [2:0] ref_cnt_q;
   reg ref_busy_q;
   // combinational write path shared by link and apb
   reg wr_en;
   reg wr_cr0;
   reg [15:0] wd;

   prlc_sync #(.W(10), .RSTV(10'h200)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d({cs_n_pin, ck_pin, dq_pin}),
      .q(pins_s)
   );
   assign cs_n_s = pins_s[9];
   assign ck_s = pins_s[8];
   assign dq_s = pins_s[7:0];

   wire cs_fall = cs_n_d_q & ~cs_n_s;
   wire cs_rise = ~cs_n_d_q & cs_n_s;
   wire ck_rise = ck_s & ~ck_d_q;
   wire ck_edge = ck_s ^ ck_d_q;
   wire apb_go = psel & penable & pready;
   wire apb_wr = apb_go & pwrite;
   wire link_wr = st_q[3] & is_reg_q & ~is_read_q & ck_edge & byte_n_q;
   wire ref_tick = (row_tmr_q == ROW_CYC - 1);
   wire reg_wr_data = st_q[3] & is_reg_q & ~is_read_q;
   // refresh never starts inside an array access; a register write is harmless
   wire ref_go = ref_pend_q & ~ref_busy_q & (st_q[0] | reg_wr_data);
   wire exit_dpd = deep_sleep_state & cs_rise;
   // refresh must already be quiet in the cycle deep sleep is entered
   wire dpd_enter = ~dpd_bit_q & ~deep_sleep_state & (dpd_cnt_q == DPD_CYC - 1);
   wire [15:0] cr0_rd = {dpd_bit_q, drive_strength, `PRLC_CR0_RSVD, lat_q, fix_q, ctl_q};
   wire [15:0] cr1_rd = {`PRLC_CR1_RSVD, clock_single_ended, hs_q, par_q, `PRLC_RST_RFI};

   always @*
   begin
      wr_en = 1'b0;
      wr_cr0 = 1'b0;
      wd = 16'h0000;
      if (link_wr)
      begin
         wr_en = 1'b1;
         wr_cr0 = ~reg_sel_q;
         wd = {hi_byte_q, dq_s};
      end
      else if (apb_wr)
      begin
         if (paddr == `PRLC_OFF_LATPWR)
         begin
            wr_en = 1'b1;
            wr_cr0 = 1'b1;
            wd = pwdata[15:0];
         end
         else if (paddr == `PRLC_OFF_REFSLP)
         begin
            wr_en = 1'b1;
            wd = pwdata[15:0];
         end
      end
   end

   // apb slave: zero wait states, ready registered
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
      else
      begin
         pready <= psel & ~penable;
         pslverr <= 1'b0;
         if (psel & ~penable)
         begin
            prdata <= 32'h00000000;
            if (paddr == `PRLC_OFF_LATPWR)
               prdata <= {16'h0000, cr0_rd};
            else if (paddr == `PRLC_OFF_REFSLP)
               prdata <= {16'h0000, cr1_rd};
            else if (paddr == `PRLC_OFF_STATUS)
               prdata <= {24'h000000, st_q, ref_busy_q, ref_pend_q, hs_q, deep_sleep_state};
            else
               pslverr <= 1'b1;
         end
      end
   end

   // configuration, sleep states and link sequencing
   always @(posedge clk)
   begin
      if (!rst_n || exit_dpd)
      begin
         drive_strength <= `PRLC_RST_DRV;
         lat_q <= `PRLC_RST_LAT;
         fix_q <= `PRLC_RST_FIX;
         ctl_q <= `PRLC_RST_BST;
         dpd_bit_q <= 1'b1;
         clock_single_ended <= `PRLC_RST_CLK;
         hs_q <= 1'b0;
         par_q <= `PRLC_RST_PAR;
         deep_sleep_state <= 1'b0;
         retention_sleep_state <= 1'b0;
         dpd_cnt_q <= 16'h0000;
         cs_n_d_q <= 1'b1;
         ck_d_q <= 1'b0;
         st_q <= L_IDLE;
         ecnt_q <= 3'h0;
         lcnt_q <= 5'h00;
         lat_txn_q <= 4'h7;
         dbl_q <= 1'b0;
         is_read_q <= 1'b0;
         is_reg_q <= 1'b0;
         reg_sel_q <= 1'b0;
         byte_n_q <= 1'b0;
         hi_byte_q <= 8'h00;
         strobe_mask_pin_o <= 1'b0;
         strobe_mask_pin_oe <= 1'b0;
         data_phase <= 1'b0;
      end
      else
      begin
         cs_n_d_q <= cs_n_s;
         ck_d_q <= ck_s;
         // select low ends retention sleep; a same-cycle write below wins
         if (cs_fall & hs_q)
            hs_q <= 1'b0;
         if (wr_en & wr_cr0)
         begin
            dpd_bit_q <= wd[`PRLC_CR0_DPD];
            drive_strength <= wd[`PRLC_CR0_DRV_HI:`PRLC_CR0_DRV_LO];
            lat_q <= wd[`PRLC_CR0_LAT_HI:`PRLC_CR0_LAT_LO];
            fix_q <= wd[`PRLC_CR0_FIX];
            ctl_q <= wd[`PRLC_CR0_BST_HI:0];
         end
         else if (wr_en)
         begin
            clock_single_ended <= wd[`PRLC_CR1_CLK];
            hs_q <= wd[`PRLC_CR1_HS];
            par_q <= wd[`PRLC_CR1_PAR_HI:`PRLC_CR1_PAR_LO];
         end
         retention_sleep_state <= hs_q & cs_n_s;
         // deep sleep entered at the latest entry time after the write
         if (!dpd_bit_q & !deep_sleep_state)
         begin
            if (dpd_cnt_q == DPD_CYC - 1)
               deep_sleep_state <= 1'b1;
            dpd_cnt_q <= dpd_cnt_q + 16'h0001;
         end
         data_phase <= 1'b0;
         // in deep sleep only select is watched: the link stays idle
         if (cs_rise | deep_sleep_state)
         begin
            st_q <= L_IDLE;
            strobe_mask_pin_oe <= 1'b0;
            strobe_mask_pin_o <= 1'b0;
         end
         else
         begin
            case (st_q)
               L_IDLE:
               begin
                  if (cs_fall)
                  begin
                     st_q <= L_CA;
                     ecnt_q <= 3'h0;
                     lat_txn_q <= lat_clocks(lat_q);
                     dbl_q <= fix_q | ref_pend_q | ref_busy_q;
                     strobe_mask_pin_oe <= 1'b1;
                     strobe_mask_pin_o <= fix_q | ref_pend_q | ref_busy_q;
                  end
               end
               L_CA:
               begin
                  if (ck_edge)
                  begin
                     ecnt_q <= ecnt_q + 3'h1;
                     if (ecnt_q == 3'h0)
                     begin
                        is_read_q <= dq_s[7];
                        is_reg_q <= dq_s[6];
                     end
                     if (ecnt_q == 3'h5)
                     begin
                        reg_sel_q <= dq_s[0];
                        byte_n_q <= 1'b0;
                        if (is_reg_q & ~is_read_q)
                        begin
                           // data follows at once, strobe released
                           st_q <= L_DATA;
                           strobe_mask_pin_oe <= 1'b0;
                           strobe_mask_pin_o <= 1'b0;
                        end
                        else
                        begin
                           st_q <= L_LAT;
                           lcnt_q <= dbl_q ? {lat_txn_q, 1'b0} : {1'b0, lat_txn_q};
                           strobe_mask_pin_oe <= is_read_q;
                           strobe_mask_pin_o <= 1'b0;
                        end
                     end
                  end
               end
               L_LAT:
               begin
                  if (ck_rise)
                  begin
                     lcnt_q <= lcnt_q - 5'h01;
                     if (lcnt_q == 5'h01)
                     begin
                        st_q <= L_DATA;
                        strobe_mask_pin_oe <= 1'b0;
                     end
                  end
               end
               L_DATA:
               begin
                  data_phase <= 1'b1;
                  if (reg_wr_data & ck_edge)
                  begin
                     byte_n_q <= ~byte_n_q;
                     hi_byte_q <= dq_s;
                  end
               end
               default:
                  st_q <= L_IDLE;
            endcase
         end
      end
   end

   // distributed refresh: one row per slot, spread over the window
   always @(posedge clk)
   begin
      if (!rst_n || exit_dpd)
      begin
         row_tmr_q <= 16'h0000;
         row_q <= {ROW_BITS{1'b0}};
         pend_row_q <= {ROW_BITS{1'b0}};
         ref_pend_q <= 1'b0;
         ref_busy_q <= 1'b0;
         ref_cnt_q <= 3'h0;
         refresh_strobe <= 1'b0;
         refresh_row <= {ROW_BITS{1'b0}};
      end
      else
      begin
         refresh_strobe <= 1'b0;
         if (deep_sleep_state | dpd_enter)
         begin
            ref_pend_q <= 1'b0;
            ref_busy_q <= 1'b0;
            row_tmr_q <= 16'h0000;
         end
         else
         begin
            row_tmr_q <= ref_tick ? 16'h0000 : row_tmr_q + 16'h0001;
            if (ref_go)
            begin
               ref_pend_q <= 1'b0;
               ref_busy_q <= 1'b1;
               ref_cnt_q <= 3'h0;
               refresh_row <= pend_row_q;
            end
            else if (ref_busy_q)
            begin
               ref_cnt_q <= ref_cnt_q + 3'h1;
               if (ref_cnt_q == `PRLC_REF_CYC - 1)
               begin
                  ref_busy_q <= 1'b0;
                  refresh_strobe <= 1'b1;
               end
            end
            // a new slot wins over the clear of the previous one
            if (ref_tick)
            begin
               row_q <= row_q + {{(ROW_BITS-1){1'b0}}, 1'b1};
               if (in_range(par_q, row_q))
               begin
                  ref_pend_q <= 1'b1;
                  pend_row_q <= row_q;
               end
            end
         end
      end
   end
endmodule // prlc_top

// ---- verif/prlc_top_properties.sv ----
// port assertions for prlc_top
// assumes the single clk domain; bound into every prlc_top
module prlc_top_properties #(
   parameter ROW_BITS = 12
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [3:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // link
   input wire logic cs_n_pin,
   input wire logic ck_pin,
   input wire logic [7:0] dq_pin,
   input wire logic strobe_mask_pin_o,
   input wire logic strobe_mask_pin_oe,
   // status
   input wire logic data_phase,
   input wire logic [2:0] drive_strength,
   input wire logic clock_single_ended,
   input wire logic deep_sleep_state,
   input wire logic retention_sleep_state,
   input wire logic refresh_strobe,
   input wire logic [ROW_BITS-1:0] refresh_row
);
   timeunit 1ns;
   timeprecision 1ps;
   logic fix_q;
   // deep sleep exit restores the fixed bit, so hold it set there
   always @(posedge clk)
   begin
      if (!rst_n || deep_sleep_state)
         fix_q <= 1'b1;
      else if (psel && penable && pready && pwrite && paddr == 4'h0)
         fix_q <= pwdata[3];
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_dpd_wr;
      psel && penable && pready && pwrite && paddr == 4'h0 && !pwdata[15];
   endsequence
   property p_ready_next;
      s_setup |=> pready;
   endproperty
   a_ready_next: assert property (p_ready_next)
      else $error("ready missing after setup");
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("ready held too long");
   property p_rst_vals;
      $rose(rst_n) |-> drive_strength == 3'h0 && clock_single_ended && !deep_sleep_state;
   endproperty
   a_rst_vals: assert property (p_rst_vals)
      else $error("wrong value after reset");
   property p_dpd_entry;
      s_dpd_wr |-> ##[1:155] deep_sleep_state;
   endproperty
   a_dpd_entry: assert property (p_dpd_entry)
      else $error("deep sleep not entered in time");
   property p_dpd_norefresh;
      deep_sleep_state |-> !refresh_strobe;
   endproperty
   a_dpd_norefresh: assert property (p_dpd_norefresh)
      else $error("refresh during deep sleep");
   property p_dpd_quiet;
      deep_sleep_state |-> !data_phase && !strobe_mask_pin_oe;
   endproperty
   a_dpd_quiet: assert property (p_dpd_quiet)
      else $error("link active in deep sleep");
   property p_dpd_exit;
      $fell(deep_sleep_state) |-> ##[0:2] (drive_strength == 3'h0 && clock_single_ended);
   endproperty
   a_dpd_exit: assert property (p_dpd_exit)
      else $error("deep sleep exit kept old settings");
   property p_fix_strobe;
      $rose(strobe_mask_pin_oe) && fix_q |-> strobe_mask_pin_o;
   endproperty
   a_fix_strobe: assert property (p_fix_strobe)
      else $error("strobe low with fixed latency");
   property p_hs_exit;
      (!cs_n_pin) [*4] |-> !retention_sleep_state;
   endproperty
   a_hs_exit: assert property (p_hs_exit)
      else $error("retention sleep kept with select low");
   property p_refresh_gap;
      refresh_strobe |=> !refresh_strobe [*8];
   endproperty
   a_refresh_gap: assert property (p_refresh_gap)
      else $error("refreshes bunched together");
endmodule // prlc_top_properties

bind prlc_top prlc_top_properties #(.ROW_BITS(ROW_BITS)) u_prlc_top_properties (
   .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .cs_n_pin, .ck_pin, .dq_pin, .strobe_mask_pin_o, .strobe_mask_pin_oe, .data_phase,
   .drive_strength, .clock_single_ended, .deep_sleep_state, .retention_sleep_state,
   .refresh_strobe, .refresh_row
);

// ---- verif/prlc_host.sv ----
// host memory controller model driving the link pins
// assumes clk at 20 ns; link clock made at 160 ns, still between frames
module prlc_host (
   // clock and observed device pins
   input wire logic clk,
   input wire logic data_phase,
   input wire logic strobe_mask_pin_o,
   input wire logic strobe_mask_pin_oe,
   // driven pins; never drives the strobe pin
   output logic cs_n_pin,
   output logic ck_pin,
   output logic [7:0] dq_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      cs_n_pin = 1'b1;
      ck_pin = 1'b0;
      dq_pin = 8'h00;
   end
   // released bus: no pull, so keep it moving
   always @(posedge clk)
   begin
      if (cs_n_pin)
         dq_pin <= ~dq_pin;
   end
   // one half link clock, data centred on the edge
   task automatic half(input logic [7:0] b);
      @(posedge clk);
      dq_pin <= b;
      repeat (2) @(posedge clk);
      ck_pin <= ~ck_pin;
      @(posedge clk);
   endtask
   task automatic xfer(input logic [7:0] b0, input logic [7:0] b5, output int lat,
      output logic sb);
      @(posedge clk);
      cs_n_pin <= 1'b0;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 6; i++)
         half(i == 0 ? b0 : (i == 5 ? b5 : 8'h00));
      sb = strobe_mask_pin_oe & strobe_mask_pin_o;
      lat = 0;
      // cap keeps select low under 4 us
      while (data_phase !== 1'b1 && lat < 20)
      begin
         half(~dq_pin);
         half(~dq_pin);
         lat++;
      end
      @(posedge clk);
      cs_n_pin <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   // register write: zero latency, high then low byte right after the command
   task automatic wreg(input logic [7:0] b5, input logic [15:0] d);
      @(posedge clk);
      cs_n_pin <= 1'b0;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 6; i++)
         half(i == 0 ? 8'h40 : (i == 5 ? b5 : 8'h00));
      half(d[15:8]);
      half(d[7:0]);
      repeat (4) @(posedge clk);
      cs_n_pin <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   task automatic pulse(input int n);
      @(posedge clk);
      cs_n_pin <= 1'b0;
      repeat (n) @(posedge clk);
      cs_n_pin <= 1'b1;
   endtask
endmodule // prlc_host

// ---- verif/tb_top.sv ----
// self-checking bench for prlc_top over apb and the link
// assumes prlc_host as far side and the bound checker
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, er, sb;
   logic [3:0] paddr;
   logic [31:0] pwdata, prdata, rd, v;
   logic cs_n_pin, ck_pin, strobe_mask_pin_o, strobe_mask_pin_oe, data_phase;
   logic [7:0] dq_pin;
   logic [2:0] drive_strength;
   logic clock_single_ended, deep_sleep_state, retention_sleep_state, refresh_strobe;
   logic [11:0] refresh_row, r0;
   int n_fail, cmp_count, lat, k, n;
   logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h2, 4'he, 4'hf};
   int clks [5] = '{5, 6, 7, 3, 4};
   prlc_top #(.ROW_BITS(12)) u_prlc_top (
      .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .cs_n_pin, .ck_pin, .dq_pin, .strobe_mask_pin_o, .strobe_mask_pin_oe, .data_phase,
      .drive_strength, .clock_single_ended, .deep_sleep_state, .retention_sleep_state,
      .refresh_strobe, .refresh_row
   );
   prlc_host u_prlc_host (
      .clk, .data_phase, .strobe_mask_pin_o, .strobe_mask_pin_oe, .cs_n_pin, .ck_pin, .dq_pin
   );
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input string nm, input logic [3:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask
   task automatic wait_rf();
      k = 0;
      do begin @(posedge clk); k++; end while (refresh_strobe !== 1'b1 && k < 2000);
   endtask
   task automatic print_verdict();
      if (n_fail == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // whole run is some 5000 clk
   initial
   begin
      #400us;
      n_fail++;
      print_verdict();
   end
   initial
   begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 4'h0;
      pwdata = 32'h0;
      n_fail = 0;
      cmp_count = 0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rdc("cr0", 4'h0, 32'h8f2f);
      rdc("cr1", 4'h4, 32'hffc1);
      apb(1'b0, 4'hc, 32'h0);
      chk("slverr", 32'h1, {31'h0, er});
      for (int i = 0; i < 8; i++)
      begin
         apb(1'b1, 4'h4, 32'hff82 | (i << 2));
         rdc("cr1 par", 4'h4, 32'hff81 | (i << 2));
      end
      chk("clk type", 32'h0, {31'h0, clock_single_ended});
      apb(1'b1, 4'h4, 32'hff90);
      // no refresh range, so only the fixed bit can double latency
      for (int f = 0; f < 2; f++)
         for (int j = 0; j < 5; j++)
         begin
            v = 32'h8f07 | ((j + 3 * f) << 12) | (codes[j] << 4) | (f << 3);
            apb(1'b1, 4'h0, v);
            rdc("cr0 lat", 4'h0, v);
            chk("drive", j + 3 * f, {29'h0, drive_strength});
            u_prlc_host.xfer(8'hc0, 8'h00, lat, sb);
            chk("strobe", f, {31'h0, sb});
            chk("latency", clks[j] * (f + 1), lat);
         end
      apb(1'b1, 4'h4, 32'hff80);
      apb(1'b1, 4'h0, 32'h8fe7);
      n = 0;
      for (int i = 0; i < 15; i++)
      begin
         u_prlc_host.xfer(8'hc0, 8'h00, lat, sb);
         chk("refresh latency", sb ? 6 : 3, lat);
         n += sb;
      end
      // a refresh slot falls inside this run, so the strobe must have shown it
      chk("refresh strobe", 1, n > 0);
      apb(1'b1, 4'h4, 32'hffa0);
      repeat (2) @(posedge clk);
      chk("hs set", 32'h1, {31'h0, retention_sleep_state});
      u_prlc_host.pulse(8);
      repeat (5) @(posedge clk);
      chk("hs exit", 32'h0, {31'h0, retention_sleep_state});
      rdc("cr1 hs", 4'h4, 32'hff81);
      u_prlc_host.wreg(8'h01, 16'hffc0);
      rdc("cr1 link", 4'h4, 32'hffc1);
      wait_rf();
      r0 = refresh_row;
      wait_rf();
      chk("refresh gap", 64000000 / 4096 / 20, k);
      chk("refresh row", r0 + 1, {20'h0, refresh_row});
      apb(1'b1, 4'h4, 32'hff90);
      repeat (10) @(posedge clk);
      n = 0;
      repeat (1600)
      begin
         @(posedge clk);
         n += (refresh_strobe === 1'b1);
      end
      chk("refresh none", 0, n);
      apb(1'b1, 4'h0, 32'h7f2f);
      k = 0;
      do begin @(posedge clk); k++; end while (deep_sleep_state !== 1'b1 && k < 300);
      chk("dpd entry", 1, k <= 155);
      u_prlc_host.pulse(15);
      repeat (10) @(posedge clk);
      chk("dpd exit", 32'h0, {31'h0, deep_sleep_state});
      rdc("cr0 dpd", 4'h0, 32'h8f2f);
      rdc("cr1 dpd", 4'h4, 32'hffc1);
      print_verdict();
   end
endmodule // tb_top
